// [logic/adcsq_map.svh]
// Register field positions and timing counts of the conversion sequencer
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
`define ADCSQ_PWR_HI_BIT 7
`define ADCSQ_PWR_LO_BIT 6
`define ADCSQ_ACQ_BIT 5
`define ADCSQ_FSCALE_BIT 4
`define ADCSQ_POLARITY_BIT 3
`define ADCSQ_CHAN_MSB 2
`define ADCSQ_CHAN_LSB 0
`define ADCSQ_ACQ_CYCLES 4'h6
`define ADCSQ_CONV_CYCLES 4'hC
`define ADCSQ_CNT_ONE 4'h1
`define ADCSQ_CNT_ZERO 4'h0
`define ADCSQ_LAST_CHAN 3'h5
`define ADCSQ_RESULT_ZERO 12'h000
`define ADCSQ_CTRL_RESET 8'h00
`endif

// [logic/adcsq_pkg.sv]
// Types shared by the conversion sequencer files
package adcsq_pkg;
    typedef enum logic [1:0] {ADCSQ_PWR_EXT, ADCSQ_PWR_INT, ADCSQ_PWR_STBY, ADCSQ_PWR_DEEP}
        adcsq_pwr_t;
    typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_ACQ_TIMED, ADCSQ_ACQ_OPEN, ADCSQ_CONV}
        adcsq_state_t;
endpackage

// [logic/adcsq_tick_gen.sv]
// Edge detector that turns the selected conversion clock into ticks
`timescale 1ns/10ps
module adcsq_tick_gen (
    input wire logic i_ref_clk,        // System clock
    input wire logic i_rst,            // Synchronous reset
    input wire logic i_ext_clk,        // External conversion clock
    input wire logic i_osc_clk,        // Internal oscillator
    adcsq_tick_if.src tk               // Tick carrier
);
    logic ext_q;
    logic osc_q;
    logic ext_rise;
    logic osc_rise;

    // Both sources sampled every cycle so switching never sees a stale edge
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ext_q <= 1'b0;
            osc_q <= 1'b0;
        end
        else
        begin
            ext_q <= i_ext_clk;
            osc_q <= i_osc_clk;
        end
    end

    // Rising edges of each source; only the chosen one counts
    assign ext_rise = i_ext_clk & ~ext_q;
    assign osc_rise = i_osc_clk & ~osc_q;
    assign tk.tick = tk.sel_int ? osc_rise : ext_rise;
endmodule

// [logic/adcsq_tick_if.sv]
// Carrier of the conversion clock tick between sequencer modules
`timescale 1ns/10ps
interface adcsq_tick_if;
    logic sel_int;
    logic tick;
    modport src (input sel_int, output tick);
    modport dst (output sel_int, input tick);
endinterface

// [logic/adcsq_top.sv]
// Conversion sequencer: control byte capture, acquisition, conversion, result bus
`timescale 1ns/10ps
`include "adcsq_map.svh"
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic i_ref_clk,          // 20 MHz system clock
    input wire logic i_rst,              // Synchronous reset, active high
    input wire logic i_cs_n,             // Chip select, active low
    input wire logic i_wr_n,             // Write strobe, active low
    input wire logic i_rd_n,             // Read strobe, active low
    input wire logic [11:0] i_data,      // Data bus input side
    output logic [11:0] o_data,          // Data bus output side
    output logic o_data_oe,              // Data bus drive enable
    input wire logic i_ext_clk,          // External conversion clock
    input wire logic i_osc_clk,          // Internal oscillator clock
    input wire logic [11:0] i_sar_code,  // Raw code from the analog core
    output logic o_done_n,               // Conversion complete, active low
    output logic o_track,                // Track/hold in tracking
    output logic o_sar_run,              // Successive approximation active
    output logic o_sar_step,             // One conversion clock tick
    output logic [5:0] o_chan_onehot,    // Input multiplexer select
    output logic o_bipolar,              // Polarity select
    output logic o_full_scale,           // Full-scale magnitude select
    output logic o_clk_int,              // Internal oscillator chosen
    output logic o_standby_shutdown,     // Standby power-down active
    output logic o_deep_shutdown         // Full power-down active
);
    adcsq_state_t state_q;
    adcsq_state_t state_d;
    logic [7:0] ctrl_q;
    logic clk_int_q;
    adcsq_pwr_t pend_pwr_q;
    adcsq_pwr_t pwr_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [11:0] result_q;
    logic done_n_q;
    logic wr_q;
    logic rd_q;
    logic sleep_q;

    // Decoded strobes; select high masks both
    logic wr_act;
    logic rd_act;
    logic wr_rise;
    logic wr_fall;
    logic rd_fall;
    assign wr_act = ~i_cs_n & ~i_wr_n;
    assign rd_act = ~i_cs_n & ~i_rd_n;
    assign wr_rise = wr_q & ~wr_act;
    assign wr_fall = wr_act & ~wr_q;
    assign rd_fall = rd_act & ~rd_q;

    // Control byte fields straight from the bus at the latching edge
    logic [7:0] new_byte;
    logic new_acq_ext;
    adcsq_pwr_t new_pwr;
    assign new_byte = i_data[7:0];
    assign new_acq_ext = new_byte[`ADCSQ_ACQ_BIT];
    assign new_pwr = adcsq_pwr_t'({new_byte[`ADCSQ_PWR_HI_BIT], new_byte[`ADCSQ_PWR_LO_BIT]});

    // Conversion clock ticks from the chosen source
    adcsq_tick_if tk ();
    assign tk.sel_int = clk_int_q;
    adcsq_tick_gen u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst (i_rst),
        .i_ext_clk (i_ext_clk),
        .i_osc_clk (i_osc_clk),
        .tk (tk)
    );
    logic tick;
    assign tick = tk.tick;

    // Conversion completes on the twelfth tick
    logic conv_done;
    logic acq_done;
    assign conv_done = (state_q == ADCSQ_CONV) && tick && (cnt_q == `ADCSQ_CNT_ONE);
    assign acq_done = (state_q == ADCSQ_ACQ_TIMED) && tick && (cnt_q == `ADCSQ_CNT_ONE);

    // Sequencer; a latched write always wins over an ongoing phase
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (wr_rise)
        begin
            if (new_acq_ext)
            begin
                state_d = ADCSQ_ACQ_OPEN;
                cnt_d = `ADCSQ_CNT_ZERO;
            end
            else if (state_q == ADCSQ_ACQ_OPEN)
            begin
                state_d = ADCSQ_CONV;
                cnt_d = `ADCSQ_CONV_CYCLES;
            end
            else
            begin
                state_d = ADCSQ_ACQ_TIMED;
                cnt_d = `ADCSQ_ACQ_CYCLES;
            end
        end
        else
        begin
            unique case (state_q)
                ADCSQ_IDLE, ADCSQ_ACQ_OPEN:
                begin
                end
                ADCSQ_ACQ_TIMED:
                begin
                    if (acq_done)
                    begin
                        state_d = ADCSQ_CONV;
                        cnt_d = `ADCSQ_CONV_CYCLES;
                    end
                    else if (tick)
                        cnt_d = cnt_q - `ADCSQ_CNT_ONE;
                end
                ADCSQ_CONV:
                begin
                    if (conv_done)
                    begin
                        state_d = ADCSQ_IDLE;
                        cnt_d = `ADCSQ_CNT_ZERO;
                    end
                    else if (tick)
                        cnt_d = cnt_q - `ADCSQ_CNT_ONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_q <= ADCSQ_IDLE;
            cnt_q <= `ADCSQ_CNT_ZERO;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wr_q <= wr_act;
            rd_q <= rd_act;
        end
    end

    // Control byte and clock source; power-down codes leave the source alone
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= `ADCSQ_CTRL_RESET;
            clk_int_q <= 1'b0;
            pend_pwr_q <= ADCSQ_PWR_EXT;
        end
        else if (wr_rise)
        begin
            ctrl_q <= new_byte;
            pend_pwr_q <= new_pwr;
            if (new_pwr == ADCSQ_PWR_EXT)
                clk_int_q <= 1'b0;
            else if (new_pwr == ADCSQ_PWR_INT)
                clk_int_q <= 1'b1;
        end
    end

    // Shutdown enters only once no conversion runs; a write falling edge wakes
    logic busy;
    logic pd_req;
    assign busy = (state_q != ADCSQ_IDLE) || (state_d != ADCSQ_IDLE);
    assign pd_req = (pend_pwr_q == ADCSQ_PWR_STBY) || (pend_pwr_q == ADCSQ_PWR_DEEP);
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            sleep_q <= 1'b0;
            pwr_q <= ADCSQ_PWR_EXT;
        end
        else if (wr_fall)
            sleep_q <= 1'b0;
        else if (pd_req && !busy && !wr_act)
        begin
            sleep_q <= 1'b1;
            pwr_q <= pend_pwr_q;
        end
    end

    // Result capture and done flag; completion beats a same-cycle read
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            result_q <= `ADCSQ_RESULT_ZERO;
            done_n_q <= 1'b1;
        end
        else if (conv_done)
        begin
            result_q <= i_sar_code;
            done_n_q <= 1'b0;
        end
        else if (rd_fall || wr_fall)
            done_n_q <= 1'b1;
    end

    // Result drive; core already codes by polarity, MSB on line 11
    assign o_data = result_q;
    assign o_data_oe = rd_act;
    assign o_done_n = done_n_q;

    // Analog front-end controls from the latched byte, the sequencer state and the power state
    logic [2:0] chan;
    assign chan = ctrl_q[`ADCSQ_CHAN_MSB:`ADCSQ_CHAN_LSB];
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_mux
            assign o_chan_onehot[gi] = (chan == 3'(gi)) && (chan <= `ADCSQ_LAST_CHAN);
        end
    endgenerate
    assign o_bipolar = ctrl_q[`ADCSQ_POLARITY_BIT];
    assign o_full_scale = ctrl_q[`ADCSQ_FSCALE_BIT];
    assign o_track = (state_q == ADCSQ_ACQ_TIMED) || (state_q == ADCSQ_ACQ_OPEN);
    assign o_sar_run = (state_q == ADCSQ_CONV);
    assign o_sar_step = o_sar_run && tick;
    assign o_clk_int = clk_int_q;
    assign o_standby_shutdown = sleep_q && (pwr_q == ADCSQ_PWR_STBY);
    assign o_deep_shutdown = sleep_q && (pwr_q == ADCSQ_PWR_DEEP);
endmodule

// [sim/adc_conversion_sequencer_tb_top.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module adc_conversion_sequencer_tb_top;
    logic clk, rst, cs_n, wr_n, rd_n, oe, ext_clk, osc_clk, done_n, track, run, step;
    logic polarity_select, fs, clk_int, stby, deep, ck;
    logic [11:0] bus, data, code;
    logic [5:0] sel;
    logic [31:0] seed;
    int mismatches, checks_done;
    adcsq_top uut (.i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_wr_n(wr_n),
        .i_rd_n(rd_n), .i_data(bus), .o_data(data), .o_data_oe(oe), .i_ext_clk(ext_clk),
        .i_osc_clk(osc_clk), .i_sar_code(code), .o_done_n(done_n), .o_track(track),
        .o_sar_run(run), .o_sar_step(step), .o_chan_onehot(sel), .o_bipolar(polarity_select),
        .o_full_scale(fs), .o_clk_int(clk_int), .o_standby_shutdown(stby),
        .o_deep_shutdown(deep));
    adcsq_host host (.i_ref_clk(clk), .i_res(data), .i_oe(oe), .o_cs_n(cs_n),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_bus(bus), .o_ext_clk(ext_clk));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [5:0] exp_sel(input logic [2:0] c);
        return (c < 3'h6) ? 6'h01 << c : 6'h00;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait for the done flag; a hang ends the run
    task automatic wait_done();
        int n;
        n = 0;
        while (done_n !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        if (done_n !== 1'b0)
        begin
            mismatches++;
            test_done();
        end
    endtask
    // Write, check decoded fields, wait, read result and power state
    task automatic convert(input logic [7:0] b, input logic et);
        logic [11:0] w;
        logic o;
        seed = xs(seed);
        @(posedge clk);
        code <= seed[11:0];
        if (!b[7])
            ck = b[6];
        host.wr_byte(b, 1'b1);
        @(negedge clk);
        `CHK("track", et, track)
        `CHK("chan", exp_sel(b[2:0]), sel)
        `CHK("pol", b[4:3], {fs, polarity_select})
        `CHK("clk", ck, clk_int)
        wait_done();
        host.rd_word(1'b1, w, o);
        `CHK("oe", 1'b1, o)
        `CHK("data", code, w)
        @(negedge clk);
        `CHK("done", 1'b1, done_n)
        `CHK("pd", {b[7] & ~b[6], b[7] & b[6]}, {stby, deep})
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Internal oscillator, deliberately unrelated to the external clock
    initial
    begin
        osc_clk = 1'b0;
        forever #300 osc_clk = ~osc_clk;
    end
    initial
    begin
        logic [11:0] w;
        logic o;
        int n;
        rst = 1'b1;
        code = 12'h000;
        seed = 32'h15;
        ck = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK("rst", 4'h8, {done_n, clk_int, stby, deep})
        // Every channel code and power code, random range and polarity
        for (n = 0; n < 8; n++)
        begin
            seed = xs(seed);
            convert({n[1:0], 1'b0, seed[4:3], n[2:0]}, 1'b1);
        end
        // Open acquisition, restarted, then closed by a same-channel write
        host.wr_byte(8'h22, 1'b1);
        repeat (300) @(negedge clk);
        `CHK("open", 2'b10, {track, run})
        host.wr_byte(8'h3A, 1'b1);
        repeat (300) @(negedge clk);
        `CHK("reopen", 2'b10, {track, run})
        convert(8'h1A, 1'b0);
        // Abort in mid-conversion
        host.wr_byte(8'h01, 1'b1);
        for (n = 0; n < 1000 && run !== 1'b1; n++)
            @(negedge clk);
        // A conversion that never starts is a hang, not a pass
        if (run !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
        convert(8'h45, 1'b1);
        // Strobes while deselected
        host.wr_byte(8'h01, 1'b0);
        @(negedge clk);
        `CHK("ignored", {3'b001, exp_sel(3'h5)}, {track, run, clk_int, sel})
        host.rd_word(1'b0, w, o);
        `CHK("float", 1'b0, o)
        test_done();
    end
endmodule
bind adcsq_top adcsq_checker chk (.i_ref_clk, .i_rst, .i_cs_n, .i_wr_n, .i_rd_n,
    .o_data_oe, .o_done_n, .o_track, .o_sar_run, .o_sar_step, .o_clk_int,
    .o_standby_shutdown, .o_deep_shutdown);

// [sim/adcsq_checker.sv]
// Port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module adcsq_checker (
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst, // Reset
    input wire logic i_cs_n, // Select
    input wire logic i_wr_n, // Write
    input wire logic i_rd_n, // Read
    input wire logic o_data_oe, // Bus enable
    input wire logic o_done_n, // Done flag
    input wire logic o_track, // Tracking
    input wire logic o_sar_run, // Converting
    input wire logic o_sar_step, // Tick
    input wire logic o_clk_int, // Clock source
    input wire logic o_standby_shutdown, // Standby
    input wire logic o_deep_shutdown // Deep
);
    logic [3:0] steps_q;
    logic [3:0] steps_d;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Ticks of the current run; an abort leaves it short
    assign steps_d = o_sar_run ? steps_q + {3'h0, o_sar_step} : 4'h0;
    always_ff @(posedge i_ref_clk)
    begin
        steps_q <= i_rst ? 4'h0 : steps_d;
    end
    a_bus_float: assert property (i_cs_n |-> !o_data_oe)
        else $error("bus driven while deselected");
    a_read_drive: assert property (!i_cs_n && !i_rd_n |-> o_data_oe)
        else $error("bus not driven in read");
    a_conv_twelve: assert property ($fell(o_sar_run) && !o_track |-> steps_q == 4'hC)
        else $error("conversion tick count wrong");
    a_done_at_end: assert property ($fell(o_sar_run) && !o_track |-> ##[0:1] !o_done_n)
        else $error("done flag missing");
    a_conv_after_acq: assert property ($rose(o_sar_run) |-> $past(o_track))
        else $error("conversion without acquisition");
    a_write_starts: assert property ($rose(i_wr_n) && !$past(i_cs_n) |=> o_track || o_sar_run)
        else $error("write did not start a cycle");
    a_wr_ignored: assert property ($rose(i_wr_n) && $past(i_cs_n) && !o_track && !o_sar_run
        |=> !o_track && !o_sar_run)
        else $error("deselected write acted");
    a_reset_state: assert property ($past(i_rst) |-> o_done_n && !o_clk_int
        && !o_standby_shutdown && !o_deep_shutdown)
        else $error("state after reset wrong");
    a_power_idle: assert property (o_standby_shutdown || o_deep_shutdown |-> !o_sar_run)
        else $error("shutdown during conversion");
    a_power_codes: assert property (!(o_standby_shutdown && o_deep_shutdown))
        else $error("both shutdowns active");
    a_read_clears: assert property ($fell(i_rd_n) && !i_cs_n && !o_sar_run |=> o_done_n)
        else $error("read did not clear done");
    c_timed_acq: cover property ($fell(o_track) && o_sar_run);
    c_abort: cover property (o_sar_run ##1 o_track);
    c_standby: cover property ($rose(o_standby_shutdown));
endmodule

// [sim/adcsq_host.sv]
// Host processor model: parallel bus cycles and external conversion clock
`timescale 1ns/10ps
module adcsq_host (
    input wire logic i_ref_clk, // Clock
    input wire logic [11:0] i_res, // Result lines
    input wire logic i_oe, // Device drives bus
    output logic o_cs_n, // Select
    output logic o_wr_n, // Write
    output logic o_rd_n, // Read
    output logic [11:0] o_bus, // Data lines
    output logic o_ext_clk // Conversion clock
);
    // Idle bus; fastest legal clock with even duty keeps runs short
    initial
    begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
        o_bus = 12'hA5A;
        o_ext_clk = 1'b0;
        forever #250 o_ext_clk = ~o_ext_clk;
    end
    // Data held one edge past the strobe so the latch edge still sees it
    task automatic wr_byte(input logic [7:0] b, input logic sel);
        @(posedge i_ref_clk);
        o_cs_n <= ~sel;
        o_wr_n <= 1'b0;
        o_bus <= {4'h0, b};
        @(posedge i_ref_clk);
        o_wr_n <= 1'b1;
        @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        o_bus <= ~{4'h0, b}; // Released lines must not look valid
    endtask
    // Select and read held low together while fetching
    task automatic rd_word(input logic sel, output logic [11:0] w, output logic oe);
        @(posedge i_ref_clk);
        o_cs_n <= ~sel;
        o_rd_n <= 1'b0;
        @(posedge i_ref_clk);
        w = i_res;
        oe = i_oe;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
    endtask
endmodule
